// [hdl/ppfm_params.svh]
// Constants of the power path fault manager: timing, register map and field layout.
// Assumes a 100 MHz block clock and a byte-addressed 32-bit register port.
`ifndef PPFM_PARAMS_SVH
`define PPFM_PARAMS_SVH

// Block clock period in nanoseconds.
`define PPFM_CLK_PERIOD_NS      10
// Current-limit fault qualification time in nanoseconds, and its cycle count rounded up.
`define PPFM_ILIM_FLT_DELAY_NS  10000
`define PPFM_ILIM_FLT_CYC       ((`PPFM_ILIM_FLT_DELAY_NS + `PPFM_CLK_PERIOD_NS - 1) / `PPFM_CLK_PERIOD_NS)
`define PPFM_ILIM_CNT_W         11
// Minimum fault hold time in nanoseconds, and its cycle count rounded up.
`define PPFM_FLT_HOLD_NS        5000000
`define PPFM_FLT_HOLD_CYC       ((`PPFM_FLT_HOLD_NS + `PPFM_CLK_PERIOD_NS - 1) / `PPFM_CLK_PERIOD_NS)
`define PPFM_HOLD_CNT_W         20

// Register byte offsets.
`define PPFM_OFS_STATUS         8'h00
`define PPFM_OFS_IRQ_EN         8'h04
`define PPFM_OFS_IRQ_CLR        8'h08
`define PPFM_OFS_LIVE           8'h0C
// Reset values.
`define PPFM_IRQ_EN_RST         10'h000
`define PPFM_STATUS_RST         10'h000

// Event bit positions in status, enable and clear registers.
`define PPFM_EV_SRC_UV          0
`define PPFM_EV_SRC_OV          1
`define PPFM_EV_SRC_ILIM        2
`define PPFM_EV_SRC_OT          3
`define PPFM_EV_SRC_RC          4
`define PPFM_EV_SNK_UV          5
`define PPFM_EV_SNK_OV          6
`define PPFM_EV_SNK_RC          7
`define PPFM_EV_SNK_OT          8
`define PPFM_EV_FAULT           9
`define PPFM_EV_NUM             10

// Path select encodings on the two enable pins.
`define PPFM_SEL_OFF            2'b00
`define PPFM_SEL_SNK            2'b01

// Number of synchronised pin inputs.
`define PPFM_SYNC_NUM           15

`endif

// [hdl/ppfm_pkg.sv]
// Types shared by the power path fault manager files.
// Assumes the constants header is included by every user of the package.
package ppfm_pkg;

	// Path control state, Gray-coded from the disabled state outward.
	typedef enum logic [1:0] {
		PPFM_ST_DIS = 2'b00,
		PPFM_ST_SRC = 2'b01,
		PPFM_ST_SNK = 2'b10
	} ppfm_state_e;

	typedef logic [7:0]  ppfm_addr_t;
	typedef logic [31:0] ppfm_word_t;
	typedef logic [9:0]  ppfm_ev_t;

endpackage

// [hdl/ppfm_sync.sv]
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes inputs are slow levels; the first stage is read by the second stage only.
`timescale 1ns/100ps

module ppfm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	////////////////////////////////////////////////////////////////////////////
	// One pair of stages per bit; the clock enable freezes both stages.
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_comb begin
				meta_d[gi] = clk_en ? din[gi] : meta_q[gi];
				sync_d[gi] = clk_en ? meta_q[gi] : sync_q[gi];
			end
		end
	endgenerate

	// Stages only register; reset clears both to a known low level.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;

	////////////////////////////////////////////////////////////////////////////
	// The output follows the pin exactly two enabled edges later.
	a_sync_two_stage: assert property (@(posedge clk) disable iff (sys_rst)
		($past(clk_en, 1) && $past(clk_en, 2) && !$past(sys_rst, 1) && !$past(sys_rst, 2))
		|-> (dout == $past(din, 2)))
		else $error("synchroniser output does not trail its input by two edges");

endmodule // ppfm_sync

// [hdl/ppfm_top.sv]
// Fault supervision for a dual power path switch: a source path and a sink path on the
// bus supply, with an open-drain active-low fault pin and a small register port.
// Assumes detector outputs and enable pins are asynchronous levels; all are synchronised.
`timescale 1ns/100ps
`include "ppfm_params.svh"

module ppfm_top #(
	parameter int unsigned FLT_HOLD_CYC = `PPFM_FLT_HOLD_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 clk_en,
	input  wire logic [1:0]           path_sel,
	input  wire logic                 source_supply_undervoltage,
	input  wire logic                 source_supply_overvoltage,
	input  wire logic                 source_current_limit,
	input  wire logic                 source_temp_rising_threshold,
	input  wire logic                 source_temp_falling_threshold,
	input  wire logic                 source_reverse_current,
	input  wire logic                 bus_undervoltage,
	input  wire logic                 bus_overvoltage,
	input  wire logic                 overvoltage_sense_input,
	input  wire logic                 sink_reverse_current,
	input  wire logic                 sink_temp_rising_threshold,
	input  wire logic                 sink_temp_falling_threshold,
	input  wire logic                 fault_n_i,
	output logic                      fault_n_o,
	output logic                      fault_n_oe,
	output logic                      source_path,
	output logic                      source_limit_3a,
	output logic                      sink_path,
	output logic                      irq,
	input  wire ppfm_pkg::ppfm_addr_t reg_addr,
	input  wire ppfm_pkg::ppfm_word_t reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output ppfm_pkg::ppfm_word_t      reg_rdata
);
	import ppfm_pkg::*;

	localparam int ILIM_CYC = `PPFM_ILIM_FLT_CYC;
	localparam logic [`PPFM_ILIM_CNT_W-1:0] ILIM_MAX = ILIM_CYC[`PPFM_ILIM_CNT_W-1:0];
	localparam logic [`PPFM_HOLD_CNT_W-1:0] HOLD_LOAD = FLT_HOLD_CYC[`PPFM_HOLD_CNT_W-1:0];

	logic [`PPFM_SYNC_NUM-1:0] pins_raw;
	logic [`PPFM_SYNC_NUM-1:0] pins_s;
	logic       src_uv, src_ov, src_il, src_trise, src_tfall, src_rc;
	logic       bus_uv, bus_ov, ovp_used, snk_rc, snk_trise, snk_tfall, flt_pin;
	logic [1:0] sel_s;

	ppfm_state_e state_q, state_d;
	logic        src_req, snk_req, src_zone, snk_zone;
	logic        src_uv_trip, snk_uv_drop;
	logic        src_ov_act, src_rc_act, snk_ov_act, snk_rc_act;
	logic        src_ot_q, src_ot_d, snk_ot_q, snk_ot_d;
	logic [`PPFM_ILIM_CNT_W-1:0] ilim_cnt_q, ilim_cnt_d;
	logic        ilim_flt;
	logic [`PPFM_HOLD_CNT_W-1:0] hold_q, hold_d;
	logic        fault_cause, fault_q, fault_d;
	logic        src_path_q, src_path_d, lim3_q, lim3_d, snk_path_q, snk_path_d;

	ppfm_ev_t   ev_now, ev_prev_q, ev_rise, ev_clr;
	ppfm_ev_t   status_q, status_d, irq_en_q, irq_en_d;
	logic       irq_q, irq_d;
	ppfm_word_t rdata_q, rdata_d, live_word;

	////////////////////////////////////////////////////////////////////////////
	// Every pin level crosses into the block clock before anything looks at it.
	assign pins_raw = {fault_n_i, path_sel, sink_temp_falling_threshold,
		sink_temp_rising_threshold, sink_reverse_current, overvoltage_sense_input,
		bus_overvoltage, bus_undervoltage, source_reverse_current,
		source_temp_falling_threshold, source_temp_rising_threshold,
		source_current_limit, source_supply_overvoltage, source_supply_undervoltage};

	ppfm_sync #(.WIDTH(`PPFM_SYNC_NUM)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.din     (pins_raw),
		.dout    (pins_s)
	);

	assign {flt_pin, sel_s, snk_tfall, snk_trise, snk_rc, ovp_used, bus_ov, bus_uv, src_rc,
		src_tfall, src_trise, src_il, src_ov, src_uv} = pins_s;

	////////////////////////////////////////////////////////////////////////////
	// Path state. Swapping roles always passes the disabled state, and a lockout holds
	// the disabled state for as long as it lasts.
	always_comb begin
		src_req     = sel_s[1];
		snk_req     = (sel_s == `PPFM_SEL_SNK);
		src_uv_trip = (state_q == PPFM_ST_SRC) && src_req && src_uv;
		snk_uv_drop = (state_q == PPFM_ST_SNK) && snk_req && bus_uv;
		state_d     = state_q;
		unique case (state_q)
			PPFM_ST_DIS: begin
				if (src_req && !src_uv) begin
					state_d = PPFM_ST_SRC;
				end else if (snk_req && !bus_uv) begin
					state_d = PPFM_ST_SNK;
				end
			end
			PPFM_ST_SRC: begin
				if (!src_req || src_uv) begin
					state_d = PPFM_ST_DIS;
				end
			end
			PPFM_ST_SNK: begin
				if (!snk_req || bus_uv) begin
					state_d = PPFM_ST_DIS;
				end
			end
			default: begin
				state_d = PPFM_ST_DIS;
			end
		endcase
		// A state being entered counts as the state itself for every protection.
		src_zone = (state_d == PPFM_ST_SRC);
		snk_zone = (state_d == PPFM_ST_SNK);
	end

	////////////////////////////////////////////////////////////////////////////
	// Protections. Temperature trips latch with hysteresis; voltage and reverse-current
	// trips follow the detector, so the path comes back as soon as they clear.
	always_comb begin
		src_ov_act = src_zone && src_ov;
		src_rc_act = src_zone && src_rc;
		snk_ov_act = snk_zone && ovp_used && bus_ov;
		snk_rc_act = snk_zone && snk_rc;
		src_ot_d   = src_ot_q ? src_tfall : (src_zone && src_trise && src_il);
		snk_ot_d   = snk_ot_q ? snk_tfall : (snk_zone && snk_trise);
		// Limiting itself leaves the path on; only a long limit episode counts as a fault.
		if (!(src_zone && src_il)) begin
			ilim_cnt_d = '0;
		end else if (ilim_cnt_q != ILIM_MAX) begin
			ilim_cnt_d = ilim_cnt_q + 1'b1;
		end else begin
			ilim_cnt_d = ilim_cnt_q;
		end
		ilim_flt   = (ilim_cnt_q == ILIM_MAX);
		src_path_d = src_zone && !src_ov_act && !src_rc_act && !src_ot_d;
		lim3_d     = src_zone && sel_s[0];
		snk_path_d = snk_zone && !snk_ov_act && !snk_rc_act && !snk_ot_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault pin. Bus undervoltage and sink reverse current are left out on purpose,
	// and a short cause still holds the pin low for the full hold time.
	always_comb begin
		fault_cause = src_uv_trip || src_ov_act || ilim_flt || src_ot_d || src_rc_act
			|| snk_ov_act || snk_ot_d;
		if (fault_cause) begin
			hold_d = HOLD_LOAD;
		end else if (hold_q != '0) begin
			hold_d = hold_q - 1'b1;
		end else begin
			hold_d = hold_q;
		end
		fault_d = fault_cause || (hold_q != '0);
	end

	// Path and fault registers; the clock enable freezes them.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q    <= PPFM_ST_DIS;
			src_ot_q   <= 1'b0;
			snk_ot_q   <= 1'b0;
			ilim_cnt_q <= '0;
			hold_q     <= '0;
			fault_q    <= 1'b0;
			src_path_q <= 1'b0;
			lim3_q     <= 1'b0;
			snk_path_q <= 1'b0;
		end else if (clk_en) begin
			state_q    <= state_d;
			src_ot_q   <= src_ot_d;
			snk_ot_q   <= snk_ot_d;
			ilim_cnt_q <= ilim_cnt_d;
			hold_q     <= hold_d;
			fault_q    <= fault_d;
			src_path_q <= src_path_d;
			lim3_q     <= lim3_d;
			snk_path_q <= snk_path_d;
		end
	end

	// The pin is only ever pulled low; the external pull-up gives the released level.
	assign fault_n_o       = 1'b0;
	assign fault_n_oe      = fault_q;
	assign source_path     = src_path_q;
	assign source_limit_3a = lim3_q;
	assign sink_path       = snk_path_q;
	assign irq             = irq_q;

	////////////////////////////////////////////////////////////////////////////
	// Sticky event flags: a new event in the cycle of its clear still sets the flag.
	assign ev_now = {fault_d, snk_ot_d, snk_rc_act, snk_ov_act, snk_uv_drop,
		src_rc_act, src_ot_d, ilim_flt, src_ov_act, src_uv_trip};
	assign ev_rise = ev_now & ~ev_prev_q;
	assign ev_clr  = (reg_wr && reg_addr == `PPFM_OFS_IRQ_CLR) ? reg_wdata[`PPFM_EV_NUM-1:0] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < `PPFM_EV_NUM; gi++) begin : g_ev
			always_comb begin
				status_d[gi] = ev_rise[gi] || (status_q[gi] && !ev_clr[gi]);
			end
		end
	endgenerate

	// Register writes, read mux and interrupt level.
	always_comb begin
		irq_en_d = irq_en_q;
		if (reg_wr && reg_addr == `PPFM_OFS_IRQ_EN) begin
			irq_en_d = reg_wdata[`PPFM_EV_NUM-1:0];
		end
		irq_d     = |(status_d & irq_en_d);
		live_word = {11'h000, flt_pin, fault_q, snk_path_q, src_path_q, lim3_q, state_q, sel_s,
			snk_tfall, snk_trise, snk_rc, ovp_used, bus_ov, bus_uv, src_rc, src_tfall,
			src_trise, src_il, src_ov, src_uv};
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`PPFM_OFS_STATUS: rdata_d = {22'h00_0000, status_q};
				`PPFM_OFS_IRQ_EN: rdata_d = {22'h00_0000, irq_en_q};
				`PPFM_OFS_LIVE:   rdata_d = live_word;
				default:          rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ev_prev_q <= '0;
			status_q  <= `PPFM_STATUS_RST;
			irq_en_q  <= `PPFM_IRQ_EN_RST;
			irq_q     <= 1'b0;
			rdata_q   <= 32'h0000_0000;
		end else if (clk_en) begin
			ev_prev_q <= ev_now;
			status_q  <= status_d;
			irq_en_q  <= irq_en_d;
			irq_q     <= irq_d;
			rdata_q   <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks. Each takes effect only across an enabled edge.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || !clk_en);

	sequence s_src_rc_gone;
		(state_q == PPFM_ST_SRC) && src_rc ##1
		(state_q == PPFM_ST_SRC) && src_req && !src_rc && !src_uv && !src_ov && !src_ot_q
		&& !(src_trise && src_il) && clk_en;
	endsequence

	a_src_uv_off: assert property ((state_q == PPFM_ST_SRC) && src_uv
		|=> (state_q == PPFM_ST_DIS) && !source_path)
		else $error("source path stayed on under source undervoltage");
	a_src_uv_hold: assert property ((state_q == PPFM_ST_DIS) && src_req && src_uv
		&& !sel_s[0] |=> (state_q == PPFM_ST_DIS))
		else $error("source state entered during source undervoltage");
	a_src_uv_flt: assert property (src_uv_trip |=> fault_n_oe && !source_path)
		else $error("source undervoltage trip did not assert fault");
	a_src_ov_trip: assert property (src_zone && src_ov |=> !source_path && fault_n_oe)
		else $error("source overvoltage did not disable path with fault");
	a_ilim_keep_on: assert property ((state_q == PPFM_ST_SRC) && src_req && src_il
		&& !src_uv && !src_ov && !src_rc && !src_ot_q && !src_trise |=> source_path)
		else $error("current limiting turned the source path off");
	a_ilim_qualify: assert property (ilim_cnt_q == ILIM_MAX |=> fault_n_oe)
		else $error("long current limit did not assert fault");
	a_src_ot_latch: assert property (src_ot_q && src_tfall |=> !source_path && fault_n_oe)
		else $error("source overtemperature released too early");
	a_src_rc_back: assert property (s_src_rc_gone |=> source_path)
		else $error("source path not re-enabled after reverse current cleared");
	a_bus_uv_sink: assert property (bus_uv && !(state_q == PPFM_ST_SNK) |=> !sink_path)
		else $error("sink path on during bus undervoltage");
	a_bus_uv_nofl: assert property (snk_uv_drop && !snk_ot_q && !snk_trise && !src_ot_q
		&& hold_q == '0 |=> !fault_n_oe && !sink_path)
		else $error("bus undervoltage drop asserted fault");
	a_snk_ov_trip: assert property (snk_zone && ovp_used && bus_ov
		|=> !sink_path && fault_n_oe)
		else $error("bus overvoltage did not disable sink with fault");
	a_snk_rc_quiet: assert property (snk_zone && snk_rc && !bus_ov && !snk_ot_q && !snk_trise
		&& hold_q == '0 && !src_ot_q |=> !sink_path && !fault_n_oe)
		else $error("sink reverse current handled wrongly");
	a_snk_ot_trip: assert property (snk_zone && snk_trise |=> !sink_path && fault_n_oe)
		else $error("sink overtemperature did not disable sink with fault");
	a_pin_drain: assert property (fault_n_oe |-> (fault_n_o == 1'b0))
		else $error("fault pin driven high");
	a_fault_hold: assert property ($rose(fault_n_oe) |-> fault_n_oe[*8])
		else $error("fault released before the hold time");
	a_hold_count: assert property (hold_q != '0 |=> fault_n_oe)
		else $error("fault released while hold counter runs");

endmodule // ppfm_top

// [sim/ppfm_pd_model.sv]
// Behavioural model of the power delivery controller that drives the two enable pins.
// Assumes one block clock; the fault pin is open drain with an external pull-up.
`timescale 1ns/100ps

module ppfm_pd_model (
	input  wire logic       clk,
	input  wire logic [1:0] want,
	input  wire logic       fault_n_o,
	input  wire logic       fault_n_oe,
	output logic      [1:0] path_sel = 2'b00,
	output logic            fault_n
);
	logic [2:0] dwell = 3'd0;

	//////////////////////////////////////////////////////////////////////////////
	// The pull-up supplies the high level whenever the device releases the pin.
	assign fault_n = fault_n_oe ? fault_n_o : 1'b1;

	// Role changes always pass the off code first and dwell there, since the device
	// expects a disabled state between source and sink.
	always @(posedge clk) begin
		if (dwell != 3'd0) begin
			dwell <= dwell - 3'd1;
		end else if (want != path_sel) begin
			if (path_sel != 2'b00 && want != 2'b00 && path_sel[1] != want[1]) begin
				path_sel <= 2'b00;
				dwell    <= 3'd4;
			end else begin
				path_sel <= want;
			end
		end
	end
endmodule // ppfm_pd_model

// [sim/ppfm_top_tb_top.sv]
// Self-checking bench for the power path fault manager: detector levels, role requests
// through the controller model, and the register port with its interrupt.
// Assumes a 100 MHz clock and a shortened fault hold of 16 cycles.
`timescale 1ns/100ps
`include "ppfm_params.svh"

module ppfm_top_tb_top;
	import ppfm_pkg::*;

	localparam int unsigned HOLD = 16;
	logic                 clk = 1'b0;
	logic                 sys_rst = 1'b1;
	logic                 clk_en = 1'b1;
	logic [11:0]          det = '0;
	logic [1:0]           want = 2'b00;
	logic [1:0]           path_sel;
	logic                 fault_n;
	logic                 fault_n_o;
	logic                 fault_n_oe;
	logic                 source_path;
	logic                 source_limit_3a;
	logic                 sink_path;
	logic                 irq;
	ppfm_addr_t           reg_addr = '0;
	ppfm_word_t           reg_wdata = '0;
	logic                 reg_wr = 1'b0;
	logic                 reg_rd = 1'b0;
	ppfm_word_t           reg_rdata;
	ppfm_word_t           d;
	int                   err_total = 0;
	int                   compares = 0;

	//////////////////////////////////////////////////////////////////////////////
	// Detector levels share the bit order of the live register for easy reading.
	ppfm_top #(.FLT_HOLD_CYC(HOLD)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .path_sel(path_sel),
		.source_supply_undervoltage(det[0]), .source_supply_overvoltage(det[1]),
		.source_current_limit(det[2]), .source_temp_rising_threshold(det[3]),
		.source_temp_falling_threshold(det[4]), .source_reverse_current(det[5]),
		.bus_undervoltage(det[6]), .bus_overvoltage(det[7]),
		.overvoltage_sense_input(det[8]), .sink_reverse_current(det[9]),
		.sink_temp_rising_threshold(det[10]), .sink_temp_falling_threshold(det[11]),
		.fault_n_i(fault_n), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
		.source_path(source_path), .source_limit_3a(source_limit_3a),
		.sink_path(sink_path), .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	ppfm_pd_model u_pd (
		.clk(clk), .want(want), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
		.path_sel(path_sel), .fault_n(fault_n));

	// Clock at 10 ns period.
	initial begin
		forever #5 clk = ~clk;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Comparison, bus and pin tasks.
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic outs(input logic [2:0] exp);
		chk("src_snk_flt", 32'(exp), 32'({source_path, sink_path, fault_n_oe}));
	endtask

	task automatic wr(input ppfm_addr_t a, input ppfm_word_t v);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input ppfm_addr_t a, output ppfm_word_t v);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Two sync stages plus the output register, with one cycle of margin.
	task automatic pin(input int i, input logic v);
		@(posedge clk);
		det[i] <= v;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// The model may dwell in the off code before the target role.
	task automatic req(input logic [1:0] v);
		@(posedge clk);
		want <= v;
		repeat (12) @(posedge clk);
		#1;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The whole run needs about 1500 cycles; a hang is cut well beyond that.
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end

	//////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		idle(1);
		outs(3'b000);
		rd(`PPFM_OFS_STATUS, d); chk("status", 32'h0000_0000, d);
		rd(`PPFM_OFS_IRQ_EN, d); chk("irq_en", 32'h0000_0000, d);
		rd(8'h10, d); chk("unmapped", 32'h0000_0000, d);
		rd(`PPFM_OFS_IRQ_CLR, d); chk("clr_read", 32'h0000_0000, d);
		// Source requested under supply undervoltage stays off, pin released.
		pin(0, 1'b1);
		req(2'b10);
		outs(3'b000);
		rd(`PPFM_OFS_LIVE, d); chk("state", 32'h0000_0000, 32'(d[15:14]));
		pin(0, 1'b0);
		outs(3'b100);
		chk("limit_15a", 32'h0000_0000, 32'(source_limit_3a));
		pin(0, 1'b1);
		outs(3'b001);
		chk("pin_low", 32'h0000_0000, 32'(fault_n));
		chk("od_data", 32'h0000_0000, 32'(fault_n_o));
		pin(0, 1'b0);
		outs(3'b101);
		idle(8);
		chk("held", 32'h0000_0001, 32'(fault_n_oe));
		idle(20);
		outs(3'b100);
		chk("pin_high", 32'h0000_0001, 32'(fault_n));
		// Overvoltage in the 3 A source state, with status and interrupt handling.
		wr(`PPFM_OFS_IRQ_CLR, 32'h0000_03FF);
		rd(`PPFM_OFS_STATUS, d); chk("status", 32'h0000_0000, d);
		req(2'b11);
		chk("limit_3a", 32'h0000_0001, 32'(source_limit_3a));
		pin(1, 1'b1);
		outs(3'b001);
		rd(`PPFM_OFS_STATUS, d); chk("status", 32'h0000_0202, d);
		idle(1); chk("rdata_gone", 32'h0000_0000, reg_rdata);
		rd(`PPFM_OFS_LIVE, d); chk("live_pin", 32'h0000_0001, 32'(d[20:19]));
		wr(`PPFM_OFS_IRQ_EN, 32'h0000_0002);
		idle(1); chk("irq_on", 32'h0000_0001, 32'(irq));
		wr(`PPFM_OFS_IRQ_EN, 32'h0000_0000);
		idle(1); chk("irq_mask", 32'h0000_0000, 32'(irq));
		wr(`PPFM_OFS_IRQ_EN, 32'h0000_0002);
		wr(`PPFM_OFS_IRQ_CLR, 32'h0000_0002);
		idle(1); chk("irq_clr", 32'h0000_0000, 32'(irq));
		rd(`PPFM_OFS_STATUS, d); chk("status", 32'h0000_0200, d);
		pin(1, 1'b0);
		idle(30);
		outs(3'b100);
		// Current limit: stays on, fault only after the qualification time.
		pin(2, 1'b1);
		outs(3'b100);
		idle(500);
		outs(3'b100);
		idle(600);
		outs(3'b101);
		pin(4, 1'b1);
		pin(3, 1'b1);
		outs(3'b001);
		pin(3, 1'b0);
		pin(2, 1'b0);
		outs(3'b001);
		pin(4, 1'b0);
		outs(3'b101);
		idle(30);
		// Reverse current: the first sync stage alone must not act.
		@(posedge clk);
		det[5] <= 1'b1;
		idle(1);
		outs(3'b100);
		idle(4);
		outs(3'b001);
		pin(5, 1'b0);
		outs(3'b101);
		idle(30);
		// Sink role under bus undervoltage, then the sink protections.
		pin(6, 1'b1);
		req(2'b01);
		outs(3'b000);
		pin(6, 1'b0);
		outs(3'b010);
		pin(6, 1'b1);
		outs(3'b000);
		pin(6, 1'b0);
		pin(7, 1'b1);
		outs(3'b010);
		pin(8, 1'b1);
		outs(3'b001);
		pin(7, 1'b0);
		pin(8, 1'b0);
		idle(30);
		outs(3'b010);
		pin(9, 1'b1);
		outs(3'b000);
		pin(9, 1'b0);
		outs(3'b010);
		pin(11, 1'b1);
		pin(10, 1'b1);
		outs(3'b001);
		pin(10, 1'b0);
		outs(3'b001);
		pin(11, 1'b0);
		outs(3'b011);
		idle(30);
		outs(3'b010);
		// A low clock enable freezes the synchroniser and every output.
		@(posedge clk);
		clk_en <= 1'b0;
		det[9] <= 1'b1;
		idle(6);
		outs(3'b010);
		@(posedge clk);
		clk_en <= 1'b1;
		idle(4);
		outs(3'b000);
		pin(9, 1'b0);
		outs(3'b010);
		print_verdict();
	end
endmodule // ppfm_top_tb_top
